//--- hw/fco_regs.vh
// fco_regs.vh: register map, field positions and reset values of the flash
// clock and option block.
// assumes: included by bare name from every design file of the block.
`ifndef FCO_REGS_VH
`define FCO_REGS_VH

// apb byte offsets
`define FCO_ADDR_W          8
`define FCO_OFS_CLK_RATIO   8'h00
`define FCO_OFS_OPTION      8'h04
`define FCO_OFS_KEY_CTL     8'h08
`define FCO_OFS_KEY_DATA    8'h0c
`define FCO_OFS_STATUS      8'h10

// clock ratio register fields
`define FCO_RATIO_LOADED_BIT 7
`define FCO_PRESCALE_BIT     6
`define FCO_RATIO_MSB        5
`define FCO_CLK_RATIO_RST    8'h00

// option shadow register fields
`define FCO_BACKDOOR_EN_BIT  7
`define FCO_REDIR_OFF_BIT    6
`define FCO_SEC_MSB          1
`define FCO_OPTION_USED_MASK 8'hc3
`define FCO_OPTION_RST       8'h00

// security codes
`define FCO_SEC_UNSECURED    2'b10
`define FCO_SEC_RST          2'b11

// key control and status fields
`define FCO_KEY_ACCESS_BIT   0
`define FCO_STAT_ACC_ERR_BIT 0
`define FCO_STAT_SECURED_BIT 1
`define FCO_STAT_BUSY_BIT    2
`define FCO_STAT_UNLOCK_BIT  3

// unlock key geometry
`define FCO_KEY_BYTES        4'h8
`define FCO_KEY_IDX_W        4

// prescale divides the bus clock by this count plus one
`define FCO_PRESCALE_DIV     3'h7

`endif

//--- hw/fco_clkdiv.v
// fco_clkdiv.v: derives the internal flash timing tick from the bus clock.
// assumes: one bus clock; ratio and prescale stay stable once loaded.
`timescale 1ns/1ps
`default_nettype none
`include "fco_regs.vh"

module fco_clkdiv (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire       prescale,
  input  wire [5:0] ratio,
  output reg        tick_r
);

  reg  [2:0] pre_cnt_r;
  reg  [5:0] div_cnt_r;
  wire       pre_tick;

  // divider input: every bus clock, or every eighth one
  assign pre_tick = !prescale || (pre_cnt_r == `FCO_PRESCALE_DIV);

  // prescaler, then divide by ratio plus one, one tick per flash clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
      tick_r    <= 1'b0;
    end else if (!run) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
      tick_r    <= 1'b0;
    end else begin
      pre_cnt_r <= prescale ? pre_cnt_r + 3'h1 : 3'h0;
      tick_r    <= 1'b0;
      if (pre_tick) begin
        if (div_cnt_r == ratio) begin
          div_cnt_r <= 6'h00;
          tick_r    <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 6'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/fco_keycmp.v
// fco_keycmp.v: collects entered key bytes and compares them with the key.
// assumes: caller gates writes by source and by backdoor enable.
`timescale 1ns/1ps
`default_nettype none
`include "fco_regs.vh"

module fco_keycmp (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clear,
  input  wire        wr,
  input  wire [7:0]  wdata,
  input  wire        check,
  input  wire [63:0] key,
  output reg         match_r
);

  reg  [63:0] entry_r;
  reg  [3:0]  idx_r;

  // bytes are taken in order, first byte into the low lane
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_r <= 64'h0;
      idx_r   <= 4'h0;
      match_r <= 1'b0;
    end else begin
      match_r <= 1'b0;
      if (clear) begin
        idx_r <= 4'h0;
      end else if (wr && idx_r != `FCO_KEY_BYTES) begin
        entry_r[idx_r[2:0]*8 +: 8] <= wdata;
        idx_r                      <= idx_r + 4'h1;
      end
      if (check) begin
        match_r <= (idx_r == `FCO_KEY_BYTES) && (entry_r == key);
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/fco_top.v
// fco_top.v: flash clock divider and option shadow registers, apb slave.
// assumes: apb3 master on pclk; nonvolatile option byte and unlock key are
// presented by the flash array; dbg_access marks accesses from debug.
// all outputs registered; the memory gate lags its inputs by one cycle.
//
// Functional notes
// - byte-wide registers, option shadow from nonvolatile byte, eight-byte unlock key.
// - ratio-loaded flag is read-only, cleared by reset, set by first write.
// - divider bits readable always, written only once after reset.
// - erase and program refused until ratio-loaded flag is set.
// - prescale bit selects bus clock or bus clock divided by eight.
// - flash clock is divider input divided by ratio plus one.
// - each timing pulse is one flash clock; the divider runs free, so an operation's first pulse can be partial.
// - every reset copies stored option byte into option shadow.
// - option bits 5 to 2 always read zero.
// - option shadow read-only; writes ignored until reprogram and reset.
// - backdoor disabled keeps key from disengaging security.
// - key comparison writes only from firmware, never from debug.
// - eight matching key bytes in order unsecure until next reset.
// - vector redirect off bit set disables redirection, clear enables.
// - security code 10 is unsecured, all others secured.
// - while secured, unsecured sources cannot reach ram or flash.
// - key match or blank check forces security code to 10.
// - blocked writes are ignored, blocked reads return zero.
// - early program or erase sets access error and is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "fco_regs.vh"

module fco_top (
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        dbg_access,
  // nonvolatile contents from the array
  input  wire [7:0]  stored_option_byte,
  input  wire [63:0] stored_unlock_key,
  input  wire        blank_check_ok,
  // program and erase requests from the command sequencer
  input  wire        pe_req,
  input  wire [7:0]  pe_pulses,
  output reg         pe_accept_r,
  output reg         pe_busy_r,
  output reg         pe_done_r,
  output reg         fclk_tick_r,
  // secure memory gate
  input  wire        mem_unsec_src,
  input  wire        mem_wr_req,
  input  wire [7:0]  mem_rdata_raw,
  output reg         mem_wr_allow_r,
  output reg  [7:0]  mem_rdata_r,
  // option outputs
  output reg         secured_r,
  output reg         vector_redirect_en_r,
  output reg         backdoor_enable_r
);

  // register state
  reg        ratio_loaded_flag;
  reg        prescale_by_eight;
  reg  [5:0] ratio_r;
  reg  [7:0] option_shadow_reg;
  reg  [1:0] security_code;
  reg        opt_pending_r;
  reg        key_access_r;
  reg        access_error_flag;
  reg        unlocked_r;
  reg  [7:0] pe_left_r;

  wire       xfer;
  wire       wr_x;
  wire       is_fw;
  wire       key_wr;
  wire       key_check;
  wire       key_match;
  wire       tick;
  wire       acc_err_set;
  wire       acc_err_clr;
  wire       sec_now;
  wire       acc_first;
  wire       wr_ratio;
  wire       wr_key_ctl;
  wire       wr_key_data;
  wire       wr_status;
  wire       key_en;
  wire       mem_block;
  wire       pe_start;
  wire [7:0] opt_rd;
  reg  [31:0] rd_mux;
  reg        addr_ok;

  // security code decode
  function is_secure;
    input [1:0] code;
    begin
      is_secure = (code != `FCO_SEC_UNSECURED);
    end
  endfunction

  // access cycle still waiting for its answer
  function acc_wait;
    input sel;
    input en;
    input rdy;
    begin
      acc_wait = sel && en && !rdy;
    end
  endfunction

  // write strobe of one register offset
  function reg_wr;
    input       wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_wr = wr && (addr == ofs);
    end
  endfunction

  // the completed access is the one where pready is seen high
  assign xfer      = psel && penable && pready;
  assign acc_first = acc_wait(psel, penable, pready);
  assign wr_x      = xfer && pwrite && addr_ok;
  assign is_fw     = !dbg_access;

  // per-register write strobes, only on the completing edge
  assign wr_ratio    = reg_wr(wr_x, paddr, `FCO_OFS_CLK_RATIO);
  assign wr_key_ctl  = reg_wr(wr_x, paddr, `FCO_OFS_KEY_CTL);
  assign wr_key_data = reg_wr(wr_x, paddr, `FCO_OFS_KEY_DATA);
  assign wr_status   = reg_wr(wr_x, paddr, `FCO_OFS_STATUS);

  // backdoor enable as loaded into the option shadow
  assign key_en = option_shadow_reg[`FCO_BACKDOOR_EN_BIT];

  // key bytes only from firmware with the backdoor enabled
  assign key_wr = wr_key_data && key_access_r && is_fw && key_en;

  // leaving key access mode from firmware launches the compare
  assign key_check = wr_key_ctl && is_fw && key_access_r
                     && !pwdata[`FCO_KEY_ACCESS_BIT];

  assign acc_err_set = pe_req && !ratio_loaded_flag;
  assign acc_err_clr = wr_status && pwdata[`FCO_STAT_ACC_ERR_BIT];
  assign sec_now     = is_secure(security_code);

  // a request starts only with the ratio loaded, idle and a nonzero count
  assign pe_start = pe_req && ratio_loaded_flag && !pe_busy_r && pe_pulses != 8'h00;

  // secure memory blocked for unsecured sources while secured
  assign mem_block = sec_now && mem_unsec_src;

  // option read-back: unused bits 5 to 2 forced to zero
  assign opt_rd = {option_shadow_reg[7:6], 4'h0, security_code};

  fco_clkdiv u_clkdiv (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (ratio_loaded_flag),
    .prescale (prescale_by_eight),
    .ratio    (ratio_r),
    .tick_r   (tick)
  );

  fco_keycmp u_keycmp (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!key_access_r),
    .wr      (key_wr),
    .wdata   (pwdata[7:0]),
    .check   (key_check && key_en),
    .key     (stored_unlock_key),
    .match_r (key_match)
  );

  // address decode and read mux
  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0;
    case (paddr)
      `FCO_OFS_CLK_RATIO: begin
        rd_mux[7:0] = {ratio_loaded_flag, prescale_by_eight, ratio_r};
      end
      `FCO_OFS_OPTION: begin
        rd_mux[7:0] = opt_rd;
      end
      `FCO_OFS_KEY_CTL: begin
        rd_mux[`FCO_KEY_ACCESS_BIT] = key_access_r;
      end
      `FCO_OFS_KEY_DATA: begin
        rd_mux = 32'h0;
      end
      `FCO_OFS_STATUS: begin
        rd_mux[`FCO_STAT_ACC_ERR_BIT] = access_error_flag;
        rd_mux[`FCO_STAT_SECURED_BIT] = sec_now;
        rd_mux[`FCO_STAT_BUSY_BIT]    = pe_busy_r;
        rd_mux[`FCO_STAT_UNLOCK_BIT]  = unlocked_r;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // apb answer: one wait cycle, data and error registered;
  // prdata returns to zero between transfers so no stale byte lingers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first && !addr_ok;
      if (acc_first && !pwrite) begin
        prdata <= addr_ok ? rd_mux : 32'h0;
      end else if (!(psel && penable)) begin
        prdata <= 32'h0;
      end
    end
  end

  // clock ratio register: write once, flag set by any first write;
  // a second write is dropped whole, so the first must carry both fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_loaded_flag <= 1'b0;
      prescale_by_eight <= 1'b0;
      ratio_r           <= 6'h00;
    end else if (wr_ratio && !ratio_loaded_flag) begin
      ratio_loaded_flag <= 1'b1;
      prescale_by_eight <= pwdata[`FCO_PRESCALE_BIT];
      ratio_r           <= pwdata[`FCO_RATIO_MSB:0];
    end
  end

  // option shadow: captured in the first cycle after reset release,
  // bus writes never reach it; the code stays secured until the capture
  // edge, so nothing is exposed in the first cycle after release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_pending_r     <= 1'b1;
      option_shadow_reg <= `FCO_OPTION_RST;
      security_code     <= `FCO_SEC_RST;
    end else begin
      if (opt_pending_r) begin
        opt_pending_r     <= 1'b0;
        option_shadow_reg <= stored_option_byte & `FCO_OPTION_USED_MASK;
        security_code     <= stored_option_byte[`FCO_SEC_MSB:0];
      end else if (key_match || blank_check_ok) begin
        security_code <= `FCO_SEC_UNSECURED;
      end
    end
  end

  // key access mode and unlock indication;
  // debug writes never enter or leave key access mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_access_r <= 1'b0;
      unlocked_r   <= 1'b0;
    end else begin
      if (wr_key_ctl && is_fw) begin
        key_access_r <= pwdata[`FCO_KEY_ACCESS_BIT];
      end
      if (key_match) begin
        unlocked_r <= 1'b1;
      end
    end
  end

  // access error flag, write one to clear, a new error wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error_flag <= 1'b0;
    end else if (acc_err_set) begin
      access_error_flag <= 1'b1;
    end else if (acc_err_clr) begin
      access_error_flag <= 1'b0;
    end
  end

  // program or erase: gated by the loaded flag, timed in flash clock pulses;
  // a request while busy or with a zero count is dropped without error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_accept_r <= 1'b0;
      pe_busy_r   <= 1'b0;
      pe_done_r   <= 1'b0;
      pe_left_r   <= 8'h00;
      fclk_tick_r <= 1'b0;
    end else begin
      pe_accept_r <= 1'b0;
      pe_done_r   <= 1'b0;
      fclk_tick_r <= tick;
      if (pe_start) begin
        pe_accept_r <= 1'b1;
        pe_busy_r   <= 1'b1;
        pe_left_r   <= pe_pulses;
      end else if (pe_busy_r && tick) begin
        if (pe_left_r == 8'h01) begin
          pe_busy_r <= 1'b0;
          pe_done_r <= 1'b1;
        end
        pe_left_r <= pe_left_r - 8'h01;
      end
    end
  end

  // option outputs follow the shadow and the live security code
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secured_r            <= 1'b1;
      vector_redirect_en_r <= 1'b0;
      backdoor_enable_r    <= 1'b0;
    end else begin
      secured_r            <= sec_now;
      vector_redirect_en_r <= !option_shadow_reg[`FCO_REDIR_OFF_BIT];
      backdoor_enable_r    <= key_en;
    end
  end

  // secure memory gate: blocked writes dropped, blocked reads give zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr_allow_r <= 1'b0;
      mem_rdata_r    <= 8'h00;
    end else begin
      mem_wr_allow_r <= mem_wr_req && !mem_block;
      mem_rdata_r    <= mem_block ? 8'h00 : mem_rdata_raw;
    end
  end

endmodule
`default_nettype wire

//--- bench/fco_checker.sv
// fco_checker.sv: port assertions for fco_top.
// assumes: bound to fco_top; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fco_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pe_accept_r,
  input wire logic        pe_busy_r,
  input wire logic        pe_done_r,
  input wire logic        fclk_tick_r,
  input wire logic        mem_unsec_src,
  input wire logic [7:0]  mem_rdata_r,
  input wire logic        mem_wr_allow_r,
  input wire logic        secured_r,
  input wire logic        vector_redirect_en_r,
  input wire logic        backdoor_enable_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       ld_r;
  logic [6:0] ratio_r;
  logic [9:0] cnt_r;
  logic       seen_r;
  wire        xfer     = psel && penable && pready;
  wire        rd_ratio = xfer && !pwrite && paddr == 8'h00;
  wire        rd_opt   = xfer && !pwrite && paddr == 8'h04;
  wire [9:0]  period   = ({4'h0, ratio_r[5:0]} + 10'h1) << (ratio_r[6] ? 3 : 0);
  // first ratio write, cycles since last tick, tick seen in this run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_r    <= 1'b0;
      ratio_r <= 7'h00;
      cnt_r   <= 10'h0;
      seen_r  <= 1'b0;
    end else begin
      if (xfer && pwrite && paddr == 8'h00 && !ld_r) begin
        ld_r    <= 1'b1;
        ratio_r <= pwdata[6:0];
      end
      cnt_r  <= fclk_tick_r ? 10'h1 : cnt_r + 10'h1;
      seen_r <= pe_busy_r && (seen_r || fclk_tick_r);
    end
  end
  property p_ld_flag; rd_ratio |-> prdata[7] == ld_r; endproperty
  a_ld_flag: assert property (p_ld_flag) else $error("loaded flag wrong");
  property p_once; rd_ratio && ld_r |-> prdata[6:0] == ratio_r; endproperty
  a_once: assert property (p_once) else $error("ratio rewritten");
  property p_refuse; pe_accept_r |-> ld_r; endproperty
  a_refuse: assert property (p_refuse) else $error("early op accepted");
  property p_tick; fclk_tick_r && pe_busy_r && seen_r |-> cnt_r == period; endproperty
  a_tick: assert property (p_tick) else $error("tick period wrong");
  property p_done; pe_done_r |-> fclk_tick_r && !pe_busy_r; endproperty
  a_done: assert property (p_done) else $error("done not after tick");
  property p_opt_zero; rd_opt |-> prdata[5:2] == 4'h0; endproperty
  a_opt_zero: assert property (p_opt_zero) else $error("unused bits set");
  property p_redir; rd_opt |-> prdata[6] == !vector_redirect_en_r; endproperty
  a_redir: assert property (p_redir) else $error("redirect wrong");
  property p_key_en; rd_opt |-> prdata[7] == backdoor_enable_r; endproperty
  a_key_en: assert property (p_key_en) else $error("backdoor flag wrong");
  property p_sec_code; rd_opt && prdata[1:0] != 2'b10 |-> secured_r; endproperty
  a_sec_code: assert property (p_sec_code) else $error("code not secured");
  property p_no_relock; !$rose(secured_r); endproperty
  a_no_relock: assert property (p_no_relock) else $error("secured again");
  property p_gate;
    secured_r && $past(mem_unsec_src) |-> mem_rdata_r == 8'h00 && !mem_wr_allow_r;
  endproperty
  a_gate: assert property (p_gate) else $error("secure access leaked");
endmodule
bind fco_top fco_checker fco_checker_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pe_accept_r, .pe_busy_r,
  .pe_done_r, .fclk_tick_r, .mem_unsec_src, .mem_rdata_r, .mem_wr_allow_r,
  .secured_r, .vector_redirect_en_r, .backdoor_enable_r);
`default_nettype wire

//--- bench/fco_top_tb.sv
// fco_top_tb.sv: register-level tests of the flash clock and option block.
// assumes: fco_top offsets from fco_regs.vh; checker bound separately.
`timescale 1ns/1ps
`default_nettype none
`include "fco_regs.vh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module fco_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, dbg_access, blank_check_ok;
  logic        pe_req, mem_unsec_src, mem_wr_req, pready, pslverr, err;
  logic        pe_accept_r, pe_busy_r, pe_done_r, fclk_tick_r, mem_wr_allow_r;
  logic        secured_r, vector_redirect_en_r, backdoor_enable_r, busy_q;
  logic [7:0]  paddr, stored_option_byte, pe_pulses, mem_rdata_raw, mem_rdata_r;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] stored_unlock_key;
  int          fails, compares, n, t;
  fco_top fco_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dbg_access, .stored_option_byte,
    .stored_unlock_key, .blank_check_ok, .pe_req, .pe_pulses, .pe_accept_r,
    .pe_busy_r, .pe_done_r, .fclk_tick_r, .mem_unsec_src, .mem_wr_req,
    .mem_rdata_raw, .mem_wr_allow_r, .mem_rdata_r, .secured_r,
    .vector_redirect_en_r, .backdoor_enable_r);
  // 40 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // one apb transfer, request held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic do_reset(input logic [7:0] opt);
    @(posedge pclk);
    stored_option_byte <= opt;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // key entry, last byte flipped by flip
  task automatic key_entry(input logic [7:0] flip);
    apb(1'b1, `FCO_OFS_KEY_CTL, 32'h1);
    for (int i = 0; i < 8; i++)
      apb(1'b1, `FCO_OFS_KEY_DATA,
          {24'h0, stored_unlock_key[8*i +: 8] ^ (i == 7 ? flip : 8'h00)});
    apb(1'b1, `FCO_OFS_KEY_CTL, 32'h0);
    repeat (4) @(posedge pclk);
  endtask
  // request np pulses; a tick output trails its pulse by one cycle, so it
  // counts when busy stood in the cycle before it
  task automatic pe_run(input logic [7:0] np);
    pe_req <= 1'b1;
    pe_pulses <= np;
    @(posedge pclk);
    pe_req <= 1'b0;
    t = 0;
    busy_q = 1'b0;
    for (n = 0; n < 1000 && pe_done_r !== 1'b1; n++) begin
      @(posedge pclk);
      if (fclk_tick_r === 1'b1 && busy_q === 1'b1) t++;
      busy_q = pe_busy_r;
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8000) @(posedge pclk);
    fails++;
    tally_and_finish;
  end
  initial begin
    {presetn, psel, penable, pwrite, dbg_access, blank_check_ok, pe_req} = 7'h0;
    {mem_unsec_src, mem_wr_req, paddr, pe_pulses, mem_rdata_raw} = 26'h0;
    pwdata = 32'h0;
    stored_option_byte = 8'hff;
    stored_unlock_key = 64'h0123456789abcdef; // arbitrary test key
    do_reset(8'hff);
    rchk("option", `FCO_OFS_OPTION, 32'hc3);
    `CHK("redirect", 1'b0, vector_redirect_en_r)
    `CHK("backdoor_enable", 1'b1, backdoor_enable_r)
    apb(1'b1, `FCO_OFS_OPTION, 32'h00);
    rchk("option ro", `FCO_OFS_OPTION, 32'hc3);
    rchk("ratio rst", `FCO_OFS_CLK_RATIO, 32'h00);
    pe_run(8'h03);
    `CHK("early ticks", 0, t)
    rchk("acc err", `FCO_OFS_STATUS, 32'h03);
    apb(1'b1, `FCO_OFS_STATUS, 32'h1);
    rchk("acc clr", `FCO_OFS_STATUS, 32'h02);
    // prescale on, ratio 25: about 192 kHz from the 40 MHz bus clock
    apb(1'b1, `FCO_OFS_CLK_RATIO, 32'h59);
    rchk("ratio", `FCO_OFS_CLK_RATIO, 32'hd9);
    apb(1'b1, `FCO_OFS_CLK_RATIO, 32'h05);
    rchk("ratio once", `FCO_OFS_CLK_RATIO, 32'hd9);
    pe_run(8'h03);
    `CHK("pulses", 3, t)
    `CHK("done", 1'b1, pe_done_r)
    rchk("unmapped", 8'h14, 32'h0);
    `CHK("slverr", 1'b1, err)
    mem_unsec_src <= 1'b1;
    mem_wr_req <= 1'b1;
    mem_rdata_raw <= 8'h5a;
    repeat (2) @(posedge pclk);
    `CHK("mem rd", 8'h00, mem_rdata_r)
    `CHK("mem wr", 1'b0, mem_wr_allow_r)
    dbg_access <= 1'b1;
    key_entry(8'h00);
    `CHK("dbg key", 1'b1, secured_r)
    dbg_access <= 1'b0;
    key_entry(8'h01);
    `CHK("bad key", 1'b1, secured_r)
    key_entry(8'h00);
    `CHK("good key", 1'b0, secured_r)
    rchk("code 10", `FCO_OFS_OPTION, 32'hc2);
    `CHK("mem open", 8'h5a, mem_rdata_r)
    `CHK("mem wr open", 1'b1, mem_wr_allow_r)
    rchk("unlocked", `FCO_OFS_STATUS, 32'h08);
    do_reset(8'h01);
    key_entry(8'h00);
    `CHK("key off", 1'b1, secured_r)
    blank_check_ok <= 1'b1;
    @(posedge pclk);
    blank_check_ok <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("blank", 1'b0, secured_r)
    do_reset(8'h02);
    rchk("opt 02", `FCO_OFS_OPTION, 32'h02);
    `CHK("unsec", 1'b0, secured_r)
    `CHK("redir on", 1'b1, vector_redirect_en_r)
    do_reset(8'h00);
    `CHK("sec 00", 1'b1, secured_r)
    tally_and_finish;
  end
endmodule
`default_nettype wire
